// >>> iprc_pkg.sv
// Constants, register map and types for the interrupt priority registers
`default_nettype none
package iprc_pkg;

    localparam int unsigned DATA_W  = 32;
    localparam int unsigned ADDR_W  = 12;
    localparam int unsigned REG_W   = 16;
    localparam int unsigned LVL_W   = 2;
    localparam int unsigned NUM_SRC = 21;

    // Printed offsets are word indices; byte address is four times the index
    localparam logic [3:0] IDX_PRI3 = 4'h3;
    localparam logic [3:0] IDX_PRI4 = 4'h4;
    localparam logic [3:0] IDX_PRI5 = 4'h5;
    localparam logic [3:0] IDX_PRI6 = 4'h6;

    localparam logic [ADDR_W-1:0] ADDR_PRI3 = {6'h00, IDX_PRI3, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PRI4 = {6'h00, IDX_PRI4, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PRI5 = {6'h00, IDX_PRI5, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PRI6 = {6'h00, IDX_PRI6, 2'h0};

    // Writable bits of each register; everything else is reserved
    localparam logic [REG_W-1:0] MASK_PRI3 = 16'h000C;
    localparam logic [REG_W-1:0] MASK_PRI4 = 16'hFC3F;
    localparam logic [REG_W-1:0] MASK_PRI5 = 16'hFF3F;
    localparam logic [REG_W-1:0] MASK_PRI6 = 16'hFFCF;
    localparam logic [REG_W-1:0] RST_PRI   = 16'h0000;
    localparam logic [DATA_W-REG_W-1:0] RD_PAD = 16'h0000;

    // Field low bit positions
    localparam int unsigned CAN_BUSOFF_LSB  = 2;
    localparam int unsigned SPI_A_RX_LSB    = 14;
    localparam int unsigned SPI_B_TX_LSB    = 12;
    localparam int unsigned SPI_B_RX_LSB    = 10;
    localparam int unsigned PORT_A_LSB      = 4;
    localparam int unsigned PORT_B_LSB      = 2;
    localparam int unsigned PORT_C_LSB      = 0;
    localparam int unsigned DEC_B_INDEX_LSB = 14;
    localparam int unsigned DEC_B_HOME_LSB  = 12;
    localparam int unsigned UART_B_RX_LSB   = 10;
    localparam int unsigned UART_B_ERR_LSB  = 8;
    localparam int unsigned UART_B_IDLE_LSB = 4;
    localparam int unsigned UART_B_TXE_LSB  = 2;
    localparam int unsigned SPI_A_TX_LSB    = 0;
    localparam int unsigned TMR_C0_LSB      = 14;
    localparam int unsigned TMR_D3_LSB      = 12;
    localparam int unsigned TMR_D2_LSB      = 10;
    localparam int unsigned TMR_D1_LSB      = 8;
    localparam int unsigned TMR_D0_LSB      = 6;
    localparam int unsigned DEC_A_INDEX_LSB = 2;
    localparam int unsigned DEC_A_HOME_LSB  = 0;

    // Field encoding: 00 disables, otherwise level is code minus one
    localparam logic [LVL_W-1:0] LVL_OFF  = 2'h0;
    localparam logic [LVL_W-1:0] LVL_STEP = 2'h1;

    // Position of each source in the request and level vectors
    localparam int unsigned SRC_CAN_BUSOFF  = 0;
    localparam int unsigned SRC_SPI_A_RX    = 1;
    localparam int unsigned SRC_SPI_B_TX    = 2;
    localparam int unsigned SRC_SPI_B_RX    = 3;
    localparam int unsigned SRC_PORT_A      = 4;
    localparam int unsigned SRC_PORT_B      = 5;
    localparam int unsigned SRC_PORT_C      = 6;
    localparam int unsigned SRC_DEC_B_INDEX = 7;
    localparam int unsigned SRC_DEC_B_HOME  = 8;
    localparam int unsigned SRC_UART_B_RX   = 9;
    localparam int unsigned SRC_UART_B_ERR  = 10;
    localparam int unsigned SRC_UART_B_IDLE = 11;
    localparam int unsigned SRC_UART_B_TXE  = 12;
    localparam int unsigned SRC_SPI_A_TX    = 13;
    localparam int unsigned SRC_TMR_C0      = 14;
    localparam int unsigned SRC_TMR_D3      = 15;
    localparam int unsigned SRC_TMR_D2      = 16;
    localparam int unsigned SRC_TMR_D1      = 17;
    localparam int unsigned SRC_TMR_D0      = 18;
    localparam int unsigned SRC_DEC_A_INDEX = 19;
    localparam int unsigned SRC_DEC_A_HOME  = 20;

    typedef enum logic [1:0] {
        IPRC_ST_IDLE   = 2'b01,
        IPRC_ST_ANSWER = 2'b10
    } iprc_state_t;

endpackage
`default_nettype wire

// >>> iprc_forward.sv
// Registered forwarding of enabled requests with their priority levels
`timescale 1ns/1ps
`default_nettype none
module iprc_forward #(
    parameter int unsigned N = 21
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic [N-1:0]               req,
    input  wire logic [N*iprc_pkg::LVL_W-1:0] fields,
    output var  logic [N-1:0]               out_valid,
    output var  logic [N*iprc_pkg::LVL_W-1:0] out_level
);
    import iprc_pkg::*;

    logic [N-1:0]       next_valid;
    logic [N*LVL_W-1:0] next_level;

    function automatic logic [LVL_W-1:0] level_of(input logic [LVL_W-1:0] code);
        level_of = (code == LVL_OFF) ? LVL_OFF : code - LVL_STEP;
    endfunction

    for (genvar i = 0; i < N; i++) begin : g_src
        assign next_valid[i] = req[i] && (fields[i*LVL_W +: LVL_W] != LVL_OFF);
        assign next_level[i*LVL_W +: LVL_W] = level_of(fields[i*LVL_W +: LVL_W]);
    end

    // One register stage so the arbiter sees glitch-free levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= '0;
            out_level <= '0;
        end else begin
            out_valid <= next_valid;
            out_level <= next_level;
        end
    end

endmodule
`default_nettype wire

// >>> iprc_regs.sv
// APB register bank for interrupt priority fields and request forwarding
// What this block does
// - Field code 00 disables the request; it is never forwarded.
// - Codes 01, 10, 11 give priority levels 0, 1, 2.
// - Reset clears every priority field, so all sources start disabled.
// - Reserved bits read as zero and ignore writes.
// - Third register: CAN bus-off field at bits 3-2, bits 1-0 reserved.
// - Fourth register: SPI A rx 15-14, SPI B tx 13-12, SPI B rx 11-10.
// - Fourth register: bits 9-6 reserved; ports A, B, C at 5-4, 3-2, 1-0.
// - Fifth register: decoder B index 15-14, home/watchdog 13-12.
// - Fifth register: UART B rx full 11-10, rx error 9-8, 7-6 reserved.
// - Fifth register: UART B tx idle 5-4, tx empty 3-2, SPI A tx 1-0.
// - Sixth register: timer C ch0 15-14, timer D ch3 13-12, ch2 11-10.
// - Sixth register: timer D ch1 9-8, ch0 7-6, bits 5-4 reserved.
// - Sixth register: decoder A index 3-2, home/watchdog 1-0.
`timescale 1ns/1ps
`default_nettype none
module iprc_regs (
    input  wire logic                                        pclk,
    input  wire logic                                        presetn,
    input  wire logic                                        psel,
    input  wire logic                                        penable,
    input  wire logic                                        pwrite,
    input  wire logic [iprc_pkg::ADDR_W-1:0]                 paddr,
    input  wire logic [iprc_pkg::DATA_W-1:0]                 pwdata,
    output var  logic [iprc_pkg::DATA_W-1:0]                 prdata,
    output var  logic                                        pready,
    output var  logic                                        pslverr,
    input  wire logic [iprc_pkg::NUM_SRC-1:0]                irq_req,
    output var  logic [iprc_pkg::NUM_SRC-1:0]                irq_valid,
    output var  logic [iprc_pkg::NUM_SRC*iprc_pkg::LVL_W-1:0] irq_level
);
    import iprc_pkg::*;

    iprc_state_t            state;
    iprc_state_t            next_state;
    logic [REG_W-1:0]       pri3;
    logic [REG_W-1:0]       pri4;
    logic [REG_W-1:0]       pri5;
    logic [REG_W-1:0]       pri6;
    logic [DATA_W-1:0]      next_prdata;
    logic                   next_pready;
    logic                   next_pslverr;

    // Address decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
        hit = (a == base);
    endfunction

    wire logic sel3    = hit(paddr, ADDR_PRI3);
    wire logic sel4    = hit(paddr, ADDR_PRI4);
    wire logic sel5    = hit(paddr, ADDR_PRI5);
    wire logic sel6    = hit(paddr, ADDR_PRI6);
    wire logic mapped  = sel3 | sel4 | sel5 | sel6;
    wire logic setup   = psel && !penable && (state == IPRC_ST_IDLE);
    // Writes land only on the edge where the access completes
    wire logic wr_ok   = psel && penable && pready && pwrite && mapped;
    wire logic [REG_W-1:0] wr_word = pwdata[REG_W-1:0];

    // Reserved bits are never stored, so they read back as zero
    wire logic [REG_W-1:0] rd_word =
        sel3 ? pri3 :
        sel4 ? pri4 :
        sel5 ? pri5 :
        sel6 ? pri6 : RST_PRI;

    // Named fields
    wire logic [LVL_W-1:0] can_busoff_level         = pri3[CAN_BUSOFF_LSB  +: LVL_W];
    wire logic [LVL_W-1:0] spi_a_rx_full_level      = pri4[SPI_A_RX_LSB    +: LVL_W];
    wire logic [LVL_W-1:0] spi_b_tx_empty_level     = pri4[SPI_B_TX_LSB    +: LVL_W];
    wire logic [LVL_W-1:0] spi_b_rx_full_level      = pri4[SPI_B_RX_LSB    +: LVL_W];
    wire logic [LVL_W-1:0] port_a_level             = pri4[PORT_A_LSB      +: LVL_W];
    wire logic [LVL_W-1:0] port_b_level             = pri4[PORT_B_LSB      +: LVL_W];
    wire logic [LVL_W-1:0] port_c_level             = pri4[PORT_C_LSB      +: LVL_W];
    wire logic [LVL_W-1:0] decoder_b_index_level    = pri5[DEC_B_INDEX_LSB +: LVL_W];
    wire logic [LVL_W-1:0] decoder_b_home_wdog_level = pri5[DEC_B_HOME_LSB +: LVL_W];
    wire logic [LVL_W-1:0] uart_b_rx_full_level     = pri5[UART_B_RX_LSB   +: LVL_W];
    wire logic [LVL_W-1:0] uart_b_rx_error_level    = pri5[UART_B_ERR_LSB  +: LVL_W];
    wire logic [LVL_W-1:0] uart_b_tx_idle_level     = pri5[UART_B_IDLE_LSB +: LVL_W];
    wire logic [LVL_W-1:0] uart_b_tx_empty_level    = pri5[UART_B_TXE_LSB  +: LVL_W];
    wire logic [LVL_W-1:0] spi_a_tx_empty_level     = pri5[SPI_A_TX_LSB    +: LVL_W];
    wire logic [LVL_W-1:0] timer_c_ch0_level        = pri6[TMR_C0_LSB      +: LVL_W];
    wire logic [LVL_W-1:0] timer_d_ch3_level        = pri6[TMR_D3_LSB      +: LVL_W];
    wire logic [LVL_W-1:0] timer_d_ch2_level        = pri6[TMR_D2_LSB      +: LVL_W];
    wire logic [LVL_W-1:0] timer_d_ch1_level        = pri6[TMR_D1_LSB      +: LVL_W];
    wire logic [LVL_W-1:0] timer_d_ch0_level        = pri6[TMR_D0_LSB      +: LVL_W];
    wire logic [LVL_W-1:0] decoder_a_index_level    = pri6[DEC_A_INDEX_LSB +: LVL_W];
    wire logic [LVL_W-1:0] decoder_a_home_wdog_level = pri6[DEC_A_HOME_LSB +: LVL_W];

    logic [NUM_SRC*LVL_W-1:0] field_vec;
    assign field_vec[SRC_CAN_BUSOFF*LVL_W  +: LVL_W] = can_busoff_level;
    assign field_vec[SRC_SPI_A_RX*LVL_W    +: LVL_W] = spi_a_rx_full_level;
    assign field_vec[SRC_SPI_B_TX*LVL_W    +: LVL_W] = spi_b_tx_empty_level;
    assign field_vec[SRC_SPI_B_RX*LVL_W    +: LVL_W] = spi_b_rx_full_level;
    assign field_vec[SRC_PORT_A*LVL_W      +: LVL_W] = port_a_level;
    assign field_vec[SRC_PORT_B*LVL_W      +: LVL_W] = port_b_level;
    assign field_vec[SRC_PORT_C*LVL_W      +: LVL_W] = port_c_level;
    assign field_vec[SRC_DEC_B_INDEX*LVL_W +: LVL_W] = decoder_b_index_level;
    assign field_vec[SRC_DEC_B_HOME*LVL_W  +: LVL_W] = decoder_b_home_wdog_level;
    assign field_vec[SRC_UART_B_RX*LVL_W   +: LVL_W] = uart_b_rx_full_level;
    assign field_vec[SRC_UART_B_ERR*LVL_W  +: LVL_W] = uart_b_rx_error_level;
    assign field_vec[SRC_UART_B_IDLE*LVL_W +: LVL_W] = uart_b_tx_idle_level;
    assign field_vec[SRC_UART_B_TXE*LVL_W  +: LVL_W] = uart_b_tx_empty_level;
    assign field_vec[SRC_SPI_A_TX*LVL_W    +: LVL_W] = spi_a_tx_empty_level;
    assign field_vec[SRC_TMR_C0*LVL_W      +: LVL_W] = timer_c_ch0_level;
    assign field_vec[SRC_TMR_D3*LVL_W      +: LVL_W] = timer_d_ch3_level;
    assign field_vec[SRC_TMR_D2*LVL_W      +: LVL_W] = timer_d_ch2_level;
    assign field_vec[SRC_TMR_D1*LVL_W      +: LVL_W] = timer_d_ch1_level;
    assign field_vec[SRC_TMR_D0*LVL_W      +: LVL_W] = timer_d_ch0_level;
    assign field_vec[SRC_DEC_A_INDEX*LVL_W +: LVL_W] = decoder_a_index_level;
    assign field_vec[SRC_DEC_A_HOME*LVL_W  +: LVL_W] = decoder_a_home_wdog_level;

    // APB answer: ready is raised in the first access cycle, so no wait states
    always_comb begin
        next_state   = state;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        next_prdata  = prdata;
        case (state)
            IPRC_ST_IDLE: begin
                if (setup) begin
                    next_state   = IPRC_ST_ANSWER;
                    next_pready  = 1'b1;
                    next_pslverr = !mapped;
                    next_prdata  = pwrite ? {DATA_W{1'b0}} : {RD_PAD, rd_word};
                end
            end
            IPRC_ST_ANSWER: begin
                next_state = IPRC_ST_IDLE;
            end
            default: begin
                next_state = IPRC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= IPRC_ST_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            state   <= next_state;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    // Masking on write keeps reserved positions at zero forever
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pri3 <= RST_PRI;
            pri4 <= RST_PRI;
            pri5 <= RST_PRI;
            pri6 <= RST_PRI;
        end else if (wr_ok) begin
            if (sel3) pri3 <= wr_word & MASK_PRI3;
            if (sel4) pri4 <= wr_word & MASK_PRI4;
            if (sel5) pri5 <= wr_word & MASK_PRI5;
            if (sel6) pri6 <= wr_word & MASK_PRI6;
        end
    end

    iprc_forward #(
        .N (NUM_SRC)
    ) u_forward (
        .pclk      (pclk),
        .presetn   (presetn),
        .req       (irq_req),
        .fields    (field_vec),
        .out_valid (irq_valid),
        .out_level (irq_level)
    );

    // Helper for the checks below
    logic [NUM_SRC-1:0] field_on;
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_on
        assign field_on[i] = (field_vec[i*LVL_W +: LVL_W] != LVL_OFF);
    end

    sequence s_write(logic [ADDR_W-1:0] a);
        psel && penable && pready && pwrite && (paddr == a);
    endsequence

    sequence s_read_setup(logic [ADDR_W-1:0] a);
        psel && !penable && !pwrite && (state == IPRC_ST_IDLE) && (paddr == a);
    endsequence

    sequence s_setup_any;
        psel && !penable && (state == IPRC_ST_IDLE);
    endsequence

    property p_off_blocks;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> ((irq_valid & ~$past(field_on)) == '0);
    endproperty
    a_off_blocks: assert property (p_off_blocks) else $error("disabled source forwarded");

    property p_level_map;
        @(posedge pclk) disable iff (!presetn)
        (can_busoff_level != LVL_OFF) |=>
            (irq_level[SRC_CAN_BUSOFF*LVL_W +: LVL_W] == $past(can_busoff_level) - LVL_STEP);
    endproperty
    a_level_map: assert property (p_level_map) else $error("level not code minus one");

    property p_reset_clear;
        @(posedge pclk) disable iff (!presetn)
        !$past(presetn) |-> ((pri3 | pri4 | pri5 | pri6) == RST_PRI) && (irq_valid == '0);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("fields not clear after reset");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        s_read_setup(ADDR_PRI4) |=> pready && ((prdata[REG_W-1:0] & ~MASK_PRI4) == RST_PRI);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

    property p_wr3;
        @(posedge pclk) disable iff (!presetn)
        s_write(ADDR_PRI3) |=> (pri3 == ($past(wr_word) & MASK_PRI3));
    endproperty
    a_wr3: assert property (p_wr3) else $error("third register write mismatch");

    property p_wr4;
        @(posedge pclk) disable iff (!presetn)
        s_write(ADDR_PRI4) |=> (pri4 == ($past(wr_word) & MASK_PRI4)) ##1 (pri4 == $past(pri4));
    endproperty
    a_wr4: assert property (p_wr4) else $error("fourth register write mismatch");

    property p_wr5;
        @(posedge pclk) disable iff (!presetn)
        s_write(ADDR_PRI5) |=> (pri5 == ($past(wr_word) & MASK_PRI5));
    endproperty
    a_wr5: assert property (p_wr5) else $error("fifth register write mismatch");

    property p_wr6;
        @(posedge pclk) disable iff (!presetn)
        s_write(ADDR_PRI6) |=> (pri6 == ($past(wr_word) & MASK_PRI6));
    endproperty
    a_wr6: assert property (p_wr6) else $error("sixth register write mismatch");

    property p_forward;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> (irq_valid == $past(irq_req & field_on));
    endproperty
    a_forward: assert property (p_forward) else $error("enabled request not forwarded");

    property p_answer;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && state == IPRC_ST_IDLE) |=> pready ##1 !pready;
    endproperty
    a_answer: assert property (p_answer) else $error("APB answer timing wrong");

    // A stray pready would let a master finish a transfer the slave never saw
    property p_no_stray_ready;
        @(posedge pclk) disable iff (!presetn)
        !(psel && !penable && (state == IPRC_ST_IDLE)) |=> !pready;
    endproperty
    a_no_stray_ready: assert property (p_no_stray_ready) else $error("pready without setup");

    property p_unmapped_answer;
        @(posedge pclk) disable iff (!presetn)
        s_setup_any ##0 !mapped |=> pready && pslverr && (prdata == '0);
    endproperty
    a_unmapped_answer: assert property (p_unmapped_answer) else $error("unmapped access not refused");

    property p_mapped_no_error;
        @(posedge pclk) disable iff (!presetn)
        s_setup_any ##0 mapped |=> pready && !pslverr;
    endproperty
    a_mapped_no_error: assert property (p_mapped_no_error) else $error("mapped access flagged");

    property p_unmapped_write_ignored;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && !mapped) |=>
            ({pri3, pri4, pri5, pri6} == $past({pri3, pri4, pri5, pri6}));
    endproperty
    a_unmapped_write_ignored: assert property (p_unmapped_write_ignored) else $error("unmapped write landed");

    property p_reserved3;
        @(posedge pclk) disable iff (!presetn)
        s_read_setup(ADDR_PRI3) |=> pready && ((prdata[REG_W-1:0] & ~MASK_PRI3) == RST_PRI);
    endproperty
    a_reserved3: assert property (p_reserved3) else $error("third register reserved bits set");

    property p_reserved5;
        @(posedge pclk) disable iff (!presetn)
        s_read_setup(ADDR_PRI5) |=> pready && ((prdata[REG_W-1:0] & ~MASK_PRI5) == RST_PRI);
    endproperty
    a_reserved5: assert property (p_reserved5) else $error("fifth register reserved bits set");

    property p_reserved6;
        @(posedge pclk) disable iff (!presetn)
        s_read_setup(ADDR_PRI6) |=> pready && ((prdata[REG_W-1:0] & ~MASK_PRI6) == RST_PRI);
    endproperty
    a_reserved6: assert property (p_reserved6) else $error("sixth register reserved bits set");

    property p_read6;
        @(posedge pclk) disable iff (!presetn)
        s_read_setup(ADDR_PRI6) |=> (prdata == {RD_PAD, $past(pri6)});
    endproperty
    a_read6: assert property (p_read6) else $error("sixth register read mismatch");

    property p_off_level_zero;
        @(posedge pclk) disable iff (!presetn)
        (timer_d_ch0_level == LVL_OFF) |=>
            !irq_valid[SRC_TMR_D0] && (irq_level[SRC_TMR_D0*LVL_W +: LVL_W] == LVL_OFF);
    endproperty
    a_off_level_zero: assert property (p_off_level_zero) else $error("disabled source shows level");

endmodule
`default_nettype wire

// >>> iprc_partner.sv
// Model of the peripheral request sources and the core's arbitration
`timescale 1ns/1ps
`default_nettype none
module iprc_partner (
    input  wire logic                                         pclk,
    input  wire logic                                         presetn,
    input  wire logic [iprc_pkg::NUM_SRC-1:0]                 req_pattern,
    output var  logic [iprc_pkg::NUM_SRC-1:0]                 irq_req,
    input  wire logic [iprc_pkg::NUM_SRC-1:0]                 irq_valid,
    input  wire logic [iprc_pkg::NUM_SRC*iprc_pkg::LVL_W-1:0] irq_level,
    output var  logic [4:0]                                   win_src,
    output var  logic [iprc_pkg::LVL_W-1:0]                   win_level,
    output var  logic                                         win_any
);
    import iprc_pkg::*;

    // Peripherals launch their levels from pclk, so requests change just after an edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req <= '0;
        end else begin
            irq_req <= req_pattern;
        end
    end

    // Highest level wins; on a tie the lowest source number keeps the grant
    always_comb begin
        win_any   = 1'b0;
        win_src   = 5'h00;
        win_level = 2'h0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (irq_valid[i] && (!win_any || irq_level[2*i +: 2] > win_level)) begin
                win_any   = 1'b1;
                win_src   = 5'(i);
                win_level = irq_level[2*i +: 2];
            end
        end
    end
endmodule
`default_nettype wire

// >>> iprc_regs_tb.sv
// Self-checking testbench for the interrupt priority register bank
`timescale 1ns/1ps
`default_nettype none
module iprc_regs_tb;
    import iprc_pkg::*;
    logic                     pclk;
    logic                     presetn;
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [ADDR_W-1:0]        paddr;
    logic [DATA_W-1:0]        pwdata;
    logic [DATA_W-1:0]        prdata;
    logic                     pready;
    logic                     pslverr;
    logic [NUM_SRC-1:0]       req_pattern;
    logic [NUM_SRC-1:0]       irq_req;
    logic [NUM_SRC-1:0]       irq_valid;
    logic [NUM_SRC*LVL_W-1:0] irq_level;
    logic [4:0]               win_src;
    logic [LVL_W-1:0]         win_level;
    logic                     win_any;
    logic [DATA_W-1:0]        rd;
    logic                     err;
    int                       num_errors;
    int                       check_count;
    // Register index and field low bit of every source, in source order
    int                       src_idx [NUM_SRC] = '{3, 4, 4, 4, 4, 4, 4, 5, 5, 5, 5, 5, 5, 5, 6, 6, 6, 6, 6, 6, 6};
    int                       src_lsb [NUM_SRC] = '{2, 14, 12, 10, 4, 2, 0, 14, 12, 10, 8, 4, 2, 0, 14, 12, 10, 8, 6, 2, 0};
    logic [15:0]              masks [4] = '{16'h000C, 16'hFC3F, 16'hFF3F, 16'hFFCF};

    iprc_regs iprc_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_req(irq_req), .irq_valid(irq_valid), .irq_level(irq_level));
    iprc_partner iprc_partner_inst (.pclk(pclk), .presetn(presetn), .req_pattern(req_pattern),
        .irq_req(irq_req), .irq_valid(irq_valid), .irq_level(irq_level), .win_src(win_src),
        .win_level(win_level), .win_any(win_any));

    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Starts one edge after entry so a release and the next setup never share a time step
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wdata);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            check(pready, 1'b1);
            report_and_stop();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic s_reset_values();
        for (int r = 0; r < 4; r++) begin
            apb(1'b0, ADDR_W'((r + 3) * 4), 32'h0000_0000);
            check({err, rd}, 64'h0);
        end
        check(irq_valid, 64'h0);
    endtask

    task automatic s_masks();
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, ADDR_W'((r + 3) * 4), 32'hFFFF_FFFF);
            apb(1'b0, ADDR_W'((r + 3) * 4), 32'h0000_0000);
            check({err, rd}, {32'h0, 16'h0000, masks[r]});
            apb(1'b1, ADDR_W'((r + 3) * 4), 32'h0000_0000);
        end
    endtask

    // Every source, every code, alone in its register with all requests active
    task automatic s_fields();
        logic [63:0] ev;
        logic [63:0] el;
        for (int i = 0; i < NUM_SRC; i++) begin
            for (int code = 0; code < 4; code++) begin
                apb(1'b1, ADDR_W'(src_idx[i] * 4), DATA_W'(code) << src_lsb[i]);
                repeat (2) @(posedge pclk);
                ev = (code != 0) ? (64'h1 << i) : 64'h0;
                el = (code != 0) ? (64'(code - 1) << (2 * i)) : 64'h0;
                check(irq_valid, ev);
                check(irq_level, el);
                check(win_any, code != 0);
                if (code != 0) begin
                    check({win_src, win_level}, {5'(i), 2'(code - 1)});
                end
            end
            apb(1'b1, ADDR_W'(src_idx[i] * 4), 32'h0000_0000);
        end
    endtask

    // Request drops and returns while its field stays programmed
    task automatic s_gating();
        apb(1'b1, 12'h014, 32'h0000_0800);
        req_pattern <= 21'h1FFDFF;
        repeat (3) @(posedge pclk);
        check(irq_valid, 64'h0);
        req_pattern <= 21'h1FFFFF;
        repeat (3) @(posedge pclk);
        check({irq_valid, irq_level}, {21'h000200, 42'h000_0004_0000});
        apb(1'b1, 12'h014, 32'h0000_0000);
    endtask

    task automatic s_unmapped();
        apb(1'b1, 12'h01C, 32'hFFFF_FFFF);
        check(err, 1'b1);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check({err, rd}, {32'h1, 32'h0});
        apb(1'b0, 12'h018, 32'h0000_0000);
        check({err, rd}, 64'h0);
    endtask

    // Reset in mid-run must wipe programmed fields as well as the outputs
    task automatic s_mid_reset();
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        check({irq_valid, irq_level}, 64'h0);
        presetn <= 1'b1;
        s_reset_values();
    endtask

    initial begin
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = '0;
        pwdata      = '0;
        req_pattern = 21'h1FFFFF;
        num_errors  = 0;
        check_count = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        s_reset_values();
        s_masks();
        s_fields();
        s_gating();
        s_unmapped();
        s_mid_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
